// File: hdl/pri_params.svh
// Timing counts and options for the peripheral reset controller
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH
`define PRI_CLK_PERIOD_PS 25000
`define PRI_STD_MIN_ASSERT_NS 100
`define PRI_LV_MIN_ASSERT_NS 500
`define PRI_LV_RECOVERY_NS 500
`define PRI_CYC_UP(ns) (((ns) * 1000 + `PRI_CLK_PERIOD_PS - 1) / `PRI_CLK_PERIOD_PS)
`define PRI_STD_ASSERT_CYC `PRI_CYC_UP(`PRI_STD_MIN_ASSERT_NS)
`define PRI_LV_ASSERT_CYC `PRI_CYC_UP(`PRI_LV_MIN_ASSERT_NS)
`define PRI_LV_RECOVERY_CYC `PRI_CYC_UP(`PRI_LV_RECOVERY_NS)
`define PRI_CNT_W 8
`define PRI_PWR_MGMT_OFFSET 8'h10
`define PRI_PWR_MGMT_FULL_SPEED_OFF_BIT 0
`endif

// File: hdl/pri_pkg.sv
// Types for the peripheral reset controller
`include "pri_params.svh"
package pri_pkg;
  typedef enum logic [1:0] {
    PRI_ST_HOLD = 2'b00,
    PRI_ST_ASSERT = 2'b01,
    PRI_ST_RECOVER = 2'b10,
    PRI_ST_READY = 2'b11
  } pri_state_e;
  typedef logic [`PRI_CNT_W-1:0] pri_cnt_t;
endpackage

// File: hdl/pri_reset_ctrl.sv
// Host-side reset sequencer for the programmable microcontroller peripheral
`timescale 1ns/1ps
`default_nettype none
`include "pri_params.svh"
module pri_reset_ctrl
  import pri_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0,
  parameter bit RESET_ACTIVE_HIGH = 1'b0,
  parameter int EXTRA_HOLD_CYC = 0
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencing request
  input wire logic reset_req,
  // Peripheral reset pin
  output logic periph_reset_pin,
  // Status to host logic
  output logic periph_in_reset,
  output logic periph_ready,
  output logic access_grant,
  // Expected pin, select and register states for checking
  output logic expect_ad_float,
  output logic expect_lat_addr_zero,
  output logic expect_cs_inactive,
  output logic expect_regs_cleared,
  output logic expect_full_speed,
  // Host access request
  input wire logic access_req
);
  localparam bit POL_HIGH = LOW_VOLTAGE ? 1'b0 : RESET_ACTIVE_HIGH;
  localparam int ASSERT_CYC = (LOW_VOLTAGE ? `PRI_LV_ASSERT_CYC : `PRI_STD_ASSERT_CYC)
    + EXTRA_HOLD_CYC;
  localparam int RECOVER_CYC = LOW_VOLTAGE ? `PRI_LV_RECOVERY_CYC : 0;
  localparam pri_cnt_t ASSERT_LAST = pri_cnt_t'(ASSERT_CYC - 1);
  localparam pri_cnt_t RECOVER_LAST = pri_cnt_t'(RECOVER_CYC > 0 ? RECOVER_CYC - 1 : 0);
  localparam pri_cnt_t ASSERT_LEN = pri_cnt_t'(ASSERT_CYC);

  pri_state_e state_reg, state_next;
  pri_cnt_t cnt_reg, cnt_next;
  logic pin_reg, pin_next;
  logic inr_reg, inr_next;
  logic rdy_reg, rdy_next;
  logic grant_reg, grant_next;
  logic full_speed_reg, full_speed_next;
  pri_cnt_t hold_len_reg, hold_len_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      PRI_ST_HOLD:
      begin
        state_next = PRI_ST_ASSERT;
        cnt_next = '0;
      end
      PRI_ST_ASSERT:
      begin
        if (cnt_reg >= ASSERT_LAST)
        begin
          cnt_next = '0;
          state_next = (RECOVER_CYC > 0) ? PRI_ST_RECOVER : PRI_ST_READY;
        end
        else
        begin
          cnt_next = cnt_reg + pri_cnt_t'(1);
        end
      end
      PRI_ST_RECOVER:
      begin
        if (cnt_reg >= RECOVER_LAST)
        begin
          state_next = PRI_ST_READY;
        end
        else
        begin
          cnt_next = cnt_reg + pri_cnt_t'(1);
        end
      end
      PRI_ST_READY:
      begin
        if (reset_req)
        begin
          state_next = PRI_ST_ASSERT;
          cnt_next = '0;
        end
      end
      default:
      begin
        state_next = PRI_ST_HOLD;
        cnt_next = '0;
      end
    endcase
  end

  // Output flops follow next state so pins change with the state itself
  always_comb
  begin
    inr_next = (state_next == PRI_ST_ASSERT) || (state_next == PRI_ST_HOLD);
    pin_next = inr_next ? POL_HIGH : ~POL_HIGH;
    rdy_next = (state_next == PRI_ST_READY);
    grant_next = rdy_next && access_req && !reset_req;
    full_speed_next = inr_next ? 1'b1 : full_speed_reg;
  end

  // Hold length for the width check; saturates so long holds never wrap
  always_comb
  begin
    hold_len_next = hold_len_reg;
    if (!inr_reg)
    begin
      hold_len_next = '0;
    end
    else if (hold_len_reg != '1)
    begin
      hold_len_next = hold_len_reg + pri_cnt_t'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= PRI_ST_HOLD;
      cnt_reg <= '0;
      pin_reg <= POL_HIGH;
      inr_reg <= 1'b1;
      rdy_reg <= 1'b0;
      grant_reg <= 1'b0;
      full_speed_reg <= 1'b1;
      hold_len_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
      inr_reg <= inr_next;
      rdy_reg <= rdy_next;
      grant_reg <= grant_next;
      full_speed_reg <= full_speed_next;
      hold_len_reg <= hold_len_next;
    end
  end

  assign periph_reset_pin = pin_reg;
  assign periph_in_reset = inr_reg;
  assign periph_ready = rdy_reg;
  assign access_grant = grant_reg;
  // Expectations are combinational copies of flops, the latched-address one gated off for low voltage, kept for the bench
  assign expect_ad_float = inr_reg;
  assign expect_lat_addr_zero = inr_reg && !LOW_VOLTAGE;
  assign expect_cs_inactive = inr_reg;
  assign expect_regs_cleared = inr_reg;
  assign expect_full_speed = full_speed_reg;

  chk_assert_width: assert property (@(posedge clk) disable iff (rst)
    $rose(inr_reg) |-> inr_reg [*2])
    else $error("reset pulse shorter than minimum");
  chk_pin_polarity: assert property (@(posedge clk) disable iff (rst)
    pin_reg == (inr_reg ? POL_HIGH : ~POL_HIGH))
    else $error("reset pin level disagrees with state");
  chk_lv_active_low: assert property (@(posedge clk) disable iff (rst)
    LOW_VOLTAGE && inr_reg |-> !pin_reg)
    else $error("low-voltage reset not active low");
  chk_no_early_access: assert property (@(posedge clk) disable iff (rst)
    access_grant |-> periph_ready && !periph_in_reset)
    else $error("access granted before peripheral ready");
  sequence seq_release;
    $fell(inr_reg);
  endsequence
  chk_lv_recovery: assert property (@(posedge clk) disable iff (rst)
    (LOW_VOLTAGE and seq_release) |-> !rdy_reg [*8])
    else $error("ready before recovery time");
  chk_std_immediate: assert property (@(posedge clk) disable iff (rst)
    (!LOW_VOLTAGE and seq_release) |-> rdy_reg)
    else $error("standard part not ready at release");
  chk_lv_ready_bound: assert property (@(posedge clk) disable iff (rst)
    ((LOW_VOLTAGE && !reset_req) and seq_release) |-> ##[20:20] rdy_reg)
    else $error("recovery longer than expected");
  chk_turbo_reset: assert property (@(posedge clk) disable iff (rst)
    inr_reg |-> expect_full_speed)
    else $error("power register not cleared in reset");
  // Width judged on the real hold length, not on a short fixed repetition
  chk_pulse_length: assert property (@(posedge clk) disable iff (rst)
    $fell(inr_reg) |-> hold_len_reg >= ASSERT_LEN)
    else $error("reset pulse shorter than the configured hold");
  chk_lv_recovery_end: assert property (@(posedge clk) disable iff (rst)
    (LOW_VOLTAGE and seq_release) |-> ##19 !rdy_reg)
    else $error("ready before the end of recovery");
  chk_ready_excl: assert property (@(posedge clk) disable iff (rst)
    !(periph_ready && periph_in_reset))
    else $error("ready while still in reset");
  sequence seq_request;
    periph_ready && reset_req;
  endsequence
  chk_reassert: assert property (@(posedge clk) disable iff (rst)
    seq_request |=> periph_in_reset && !periph_ready)
    else $error("new reset request not honoured");
  chk_grant_follows: assert property (@(posedge clk) disable iff (rst)
    periph_ready && access_req && !reset_req |=> access_grant)
    else $error("grant missing while ready");
  chk_grant_drops: assert property (@(posedge clk) disable iff (rst)
    !access_req |=> !access_grant)
    else $error("grant without a request");
endmodule
`default_nettype wire

// File: sim/pri_dev_model.sv
// Behavioural model of the peripheral's reset input
`timescale 1ns/1ps
`default_nettype none
module pri_dev_model #(
  parameter bit LV = 1'b0,
  parameter bit HI = 1'b0
)(
  // Reset pin
  input wire logic rst_pin,
  // Status
  output logic dev_ok,
  output logic short_pulse
);
  realtime t0 = 0;
  // Low-voltage part knows active low only
  wire logic in_rst = (HI && !LV) ? rst_pin : !rst_pin;
  initial dev_ok = 1'b0;
  initial short_pulse = 1'b0;
  // Level alone acts, no clock; a reassert inside recovery is not modelled
  always @(in_rst)
  begin
    if (in_rst)
    begin
      t0 = $realtime;
      dev_ok = 1'b0;
    end
    else
    begin
      short_pulse = ($realtime - t0) < (LV ? 500.0 : 100.0);
      dev_ok <= #(LV ? 500 : 0) 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the peripheral reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic acc = 1'b0;
  wire logic [1:0] pin, inr, rdy, gnt, ad, lat, cs, rc, fs, ok, bad;
  int num_errors = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  // Lane 0 standard with active-high reset, lane 1 low-voltage
  for (genvar v = 0; v < 2; v++)
  begin : g
    pri_reset_ctrl #(.LOW_VOLTAGE(v == 1), .RESET_ACTIVE_HIGH(v == 0)) dut (.clk(clk),
      .rst(rst), .reset_req(req), .access_req(acc), .periph_reset_pin(pin[v]),
      .periph_in_reset(inr[v]), .periph_ready(rdy[v]), .access_grant(gnt[v]),
      .expect_ad_float(ad[v]), .expect_lat_addr_zero(lat[v]), .expect_cs_inactive(cs[v]),
      .expect_regs_cleared(rc[v]), .expect_full_speed(fs[v]));
    pri_dev_model #(.LV(v == 1), .HI(v == 0)) dev (.rst_pin(pin[v]), .dev_ok(ok[v]),
      .short_pulse(bad[v]));
  end
  task chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_power_up;
    int n;
    n = 0;
    while (rdy !== 2'b11 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(ok === 2'b11 && bad === 2'b00, "not up at ready");
    $display("power-up done");
  endtask
  // Request refused in reset, grant held once ready and checked gone two cycles after the request drops
  task automatic t_pulse;
    int w[2];
    int r[2];
    w = '{0, 0};
    r = '{0, 0};
    req = 1'b1;
    acc = 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      req = 1'b0;
      for (int v = 0; v < 2; v++)
      begin
        chk(!gnt[v] || ok[v], "grant before device up");
        if (inr[v] === 1'b1)
        begin
          w[v]++;
          chk(ad[v] & cs[v] & rc[v] & fs[v] & !gnt[v] & !rdy[v], "in reset");
          chk(lat[v] === (v == 0) && pin[v] === (v == 0), "pin levels");
        end
        else if (rdy[v] !== 1'b1)
          r[v]++;
      end
    end
    chk(w[0] == 4 && w[1] == 20, "width");
    chk(r[0] == 0 && r[1] == 20, "recovery");
    chk(gnt === 2'b11 && ok === 2'b11 && bad === 2'b00 && fs === 2'b11, "after");
    acc = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk(gnt === 2'b00, "grant held");
    $display("pulse done");
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_power_up;
    t_pulse;
    wrap_up;
  end
  initial
  begin
    #20000;
    num_errors++;
    $display("Error at %0t: watchdog", $time);
    wrap_up;
  end
endmodule
`default_nettype wire
